// ---- pcd_defines.svh ----
// offsets, field positions, reset values and sizes for the bar decode and dma register block
// assumes a 32-bit register word and byte addresses within the control bar
`ifndef PCD_DEFINES_SVH
`define PCD_DEFINES_SVH

// control register byte offsets within the control bar
`define PCD_OFS_LINK_LO 12'h000
`define PCD_OFS_LINK_HI 12'h004
`define PCD_OFS_LENGTH 12'h008
`define PCD_OFS_CTRL 12'h00c
`define PCD_OFS_LMEM 12'h014

// control word fields
`define PCD_CTRL_BUSY_BIT 31
`define PCD_CTRL_DIR_BIT 0

// reset values
`define PCD_RST_WORD 32'h0000_0000

// target ram size in bytes and first ignored address bit
`define PCD_RAM_BYTES 32768
`define PCD_RAM_TOP_BIT 15

// bar numbers as carried with a request
`define PCD_BAR_CTRL 3'h2
`define PCD_BAR_LAST 3'h5

// bytes moved per dma beat
`define PCD_BEAT_BYTES 32'h0000_0004

`endif

// ---- pcd_pkg.sv ----
// types shared by the device end and the host end
// assumes pcd_defines.svh for the numbers
package pcd_pkg;
    // device dma engine states
    typedef enum logic [1:0] {DMA_IDLE, DMA_ISSUE, DMA_WAIT} pcd_dma_st_t;
    // host sequencer states
    typedef enum logic [1:0] {H_IDLE, H_SETUP, H_POLL, H_WAIT} pcd_host_st_t;
endpackage

// ---- pcd_link_if.sv ----
// link between the endpoint application and the host, at packet level
// assumes one common clock for both ends
`timescale 1ns/100ps
`default_nettype none
interface pcd_link_if;
    // host requests into the endpoint
    logic rq_valid;
    logic rq_ready;
    logic [2:0] rq_bar;
    logic rq_write;
    logic [63:0] rq_addr;
    logic [31:0] rq_data;
    logic [3:0] rq_be;
    // completions for host reads
    logic cp_valid;
    logic [31:0] cp_data;
    // dma requests from the endpoint
    logic dm_valid;
    logic dm_ready;
    logic dm_write;
    logic [63:0] dm_addr;
    logic [31:0] dm_data;
    // read data for dma reads
    logic dr_valid;
    logic [31:0] dr_data;

    modport dev (
        input rq_valid, rq_bar, rq_write, rq_addr, rq_data, rq_be, dm_ready, dr_valid, dr_data,
        output rq_ready, cp_valid, cp_data, dm_valid, dm_write, dm_addr, dm_data
    );
    modport host (
        output rq_valid, rq_bar, rq_write, rq_addr, rq_data, rq_be, dm_ready, dr_valid, dr_data,
        input rq_ready, cp_valid, cp_data, dm_valid, dm_write, dm_addr, dm_data
    );
endinterface
`default_nettype wire

// ---- pcd_host_end.sv ----
// host end: issues user requests, runs the dma setup sequence, serves dma traffic
// assumes the device end on the other side of pcd_link_if, same clock
`timescale 1ns/100ps
`default_nettype none
`include "pcd_defines.svh"
module pcd_host_end import pcd_pkg::*; #(
    parameter int HMEM_WORDS = 256
) (
    input wire logic clk,
    input wire logic sys_rst,
    pcd_link_if.host lnk,
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire logic cmd_write,
    input wire logic [2:0] cmd_bar,
    input wire logic [63:0] cmd_addr,
    input wire logic [31:0] cmd_wdata,
    input wire logic [3:0] cmd_be,
    output logic rsp_valid,
    output logic [31:0] rsp_data,
    input wire logic dma_go,
    input wire logic [63:0] dma_link_addr,
    input wire logic [31:0] dma_local_addr,
    input wire logic [31:0] dma_len,
    input wire logic [30:0] dma_attr,
    output logic dma_idle,
    output logic dma_finished
);
    localparam int HAW = $clog2(HMEM_WORDS);

    pcd_host_st_t st_q;
    logic [2:0] step_q;
    logic [63:0] link_q;
    logic [31:0] lmem_q;
    logic [31:0] len_q;
    logic [30:0] attr_q;
    logic rd_wait_q;
    logic rq_valid_q;
    logic [2:0] rq_bar_q;
    logic rq_write_q;
    logic [63:0] rq_addr_q;
    logic [31:0] rq_data_q;
    logic [3:0] rq_be_q;
    logic [31:0] hmem [HMEM_WORDS];
    logic dr_valid_q;
    logic [31:0] dr_data_q;
    logic [11:0] set_ofs;
    logic [31:0] set_val;
    logic take_cmd;

    // setup order: link address, local address, length, attributes last
    always_comb begin
        case (step_q)
            3'h0: begin set_ofs = `PCD_OFS_LINK_LO; set_val = link_q[31:0]; end
            3'h1: begin set_ofs = `PCD_OFS_LINK_HI; set_val = link_q[63:32]; end
            3'h2: begin set_ofs = `PCD_OFS_LMEM; set_val = lmem_q; end
            3'h3: begin set_ofs = `PCD_OFS_LENGTH; set_val = len_q; end
            default: begin set_ofs = `PCD_OFS_CTRL; set_val = {1'b0, attr_q}; end
        endcase
    end

    // user port is free only with no sequence and nothing outstanding
    assign cmd_ready = (st_q == H_IDLE) && !rq_valid_q && !rd_wait_q && !dma_go;
    assign take_cmd = cmd_valid && cmd_ready;
    assign dma_idle = (st_q == H_IDLE);

    // sequencer and request register
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            st_q <= H_IDLE;
            step_q <= 3'h0;
            link_q <= 64'h0;
            lmem_q <= 32'h0;
            len_q <= 32'h0;
            attr_q <= 31'h0;
            rd_wait_q <= 1'b0;
            rq_valid_q <= 1'b0;
            rq_bar_q <= 3'h0;
            rq_write_q <= 1'b0;
            rq_addr_q <= 64'h0;
            rq_data_q <= 32'h0;
            rq_be_q <= 4'h0;
            dma_finished <= 1'b0;
        end else begin
            dma_finished <= 1'b0;
            if (rq_valid_q && lnk.rq_ready) begin
                rq_valid_q <= 1'b0;
            end
            case (st_q)
                H_IDLE: begin
                    if (lnk.cp_valid) begin
                        rd_wait_q <= 1'b0;
                    end
                    if (dma_go && !rq_valid_q && !rd_wait_q) begin
                        link_q <= dma_link_addr;
                        lmem_q <= dma_local_addr;
                        len_q <= dma_len;
                        attr_q <= dma_attr;
                        step_q <= 3'h0;
                        st_q <= H_SETUP;
                    end else if (take_cmd && cmd_bar <= `PCD_BAR_LAST) begin
                        rq_valid_q <= 1'b1;
                        rq_bar_q <= cmd_bar;
                        rq_write_q <= cmd_write;
                        rq_addr_q <= cmd_addr;
                        rq_data_q <= cmd_wdata;
                        rq_be_q <= cmd_be;
                        rd_wait_q <= !cmd_write;
                    end
                end
                H_SETUP: begin
                    if (!rq_valid_q) begin
                        rq_valid_q <= 1'b1;
                        rq_bar_q <= `PCD_BAR_CTRL;
                        rq_write_q <= 1'b1;
                        rq_addr_q <= {52'h0, set_ofs};
                        rq_data_q <= set_val;
                        rq_be_q <= 4'hf;
                        step_q <= step_q + 3'h1;
                        if (step_q == 3'h4) begin
                            st_q <= H_POLL;
                        end
                    end
                end
                H_POLL: begin
                    if (!rq_valid_q) begin
                        rq_valid_q <= 1'b1;
                        rq_write_q <= 1'b0;
                        rq_addr_q <= {52'h0, `PCD_OFS_CTRL};
                        st_q <= H_WAIT;
                    end
                end
                default: begin
                    // poll until the busy flag reads clear
                    if (lnk.cp_valid) begin
                        if (lnk.cp_data[`PCD_CTRL_BUSY_BIT]) begin
                            st_q <= H_POLL;
                        end else begin
                            st_q <= H_IDLE;
                            dma_finished <= 1'b1;
                        end
                    end
                end
            endcase
        end
    end

    assign lnk.rq_valid = rq_valid_q;
    assign lnk.rq_bar = rq_bar_q;
    assign lnk.rq_write = rq_write_q;
    assign lnk.rq_addr = rq_addr_q;
    assign lnk.rq_data = rq_data_q;
    assign lnk.rq_be = rq_be_q;

    // user read answers, polls stay internal
    assign rsp_valid = lnk.cp_valid && (st_q == H_IDLE);
    assign rsp_data = lnk.cp_data;

    // host memory serving dma traffic, preset to its own index
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            for (int i = 0; i < HMEM_WORDS; i++) begin
                hmem[i] <= 32'(i);
            end
            dr_valid_q <= 1'b0;
            dr_data_q <= 32'h0;
        end else begin
            dr_valid_q <= lnk.dm_valid && !lnk.dm_write;
            if (lnk.dm_valid && lnk.dm_write) begin
                hmem[lnk.dm_addr[HAW+1:2]] <= lnk.dm_data;
            end
            if (lnk.dm_valid && !lnk.dm_write) begin
                dr_data_q <= hmem[lnk.dm_addr[HAW+1:2]];
            end
        end
    end

    assign lnk.dm_ready = 1'b1;
    assign lnk.dr_valid = dr_valid_q;
    assign lnk.dr_data = dr_data_q;
endmodule
`default_nettype wire

// ---- pcd_dev_end.sv ----
// device end: bar steering to target ram or control registers, plus one dma channel
// assumes the host end on pcd_link_if, same clock, no other host traffic during a dma
//
// Notes on behaviour
// - bars 0,1,4,5 reach the target ram
// - ram index ignores address bit 15 upward
// - bars 2,3 reach the control registers
// - host avoids rom and io bars
// - host writes link address words first
// - host then writes local memory address
// - host then writes the byte length
// - control word written last starts dma
// - control bit 0 picks write or read
// - busy flag polled at control word
// - word 0x00 holds link address low
// - word 0x04 holds link address high
// - bit 31 read-only, one while running
// - word 0x08 holds length in bytes
`timescale 1ns/100ps
`default_nettype none
`include "pcd_defines.svh"
module pcd_dev_end import pcd_pkg::*; #(
    parameter int RAM_BYTES = `PCD_RAM_BYTES,
    parameter int LMEM_WORDS = 256
) (
    input wire logic clk,
    input wire logic sys_rst,
    pcd_link_if.dev lnk,
    output logic dma_busy,
    output logic dma_done
);
    localparam int RAM_WORDS = RAM_BYTES / 4;
    localparam int RAW = $clog2(RAM_WORDS);
    localparam int LAW = $clog2(LMEM_WORDS);

    logic [31:0] ram [RAM_WORDS];
    logic [31:0] lmem [LMEM_WORDS];
    logic [31:0] link_lo_q;
    logic [31:0] link_hi_q;
    logic [31:0] len_q;
    logic [30:0] ctrl_q;
    logic [31:0] lmem_addr_q;
    logic cp_valid_q;
    logic [31:0] cp_data_q;
    pcd_dma_st_t st_q;
    logic [63:0] cur_link_q;
    logic [31:0] cur_lmem_q;
    logic [31:0] left_q;
    logic take;
    logic hit_ram;
    logic hit_reg;
    logic [RAW-1:0] ram_idx;
    logic [11:0] ofs;
    logic [31:0] reg_rd;
    logic start;
    logic beat_done;
    logic last_beat;
    logic [31:0] ctrl_merged;

    // merge written byte lanes into an old word
    function automatic logic [31:0] merge_be(input logic [31:0] old, input logic [31:0] nw,
                                             input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                r[8*b +: 8] = nw[8*b +: 8];
            end
        end
        return r;
    endfunction

    // every request is taken at once
    assign lnk.rq_ready = 1'b1;
    assign take = lnk.rq_valid;
    assign hit_ram = (lnk.rq_bar <= 3'h1) || (lnk.rq_bar == 3'h4) || (lnk.rq_bar == 3'h5);
    assign hit_reg = (lnk.rq_bar == 3'h2) || (lnk.rq_bar == 3'h3);
    assign ram_idx = lnk.rq_addr[RAW+1:2];
    assign ofs = {lnk.rq_addr[11:2], 2'b00};

    // register read decode
    always_comb begin
        if (ofs == `PCD_OFS_LINK_LO) begin
            reg_rd = link_lo_q;
        end else if (ofs == `PCD_OFS_LINK_HI) begin
            reg_rd = link_hi_q;
        end else if (ofs == `PCD_OFS_LENGTH) begin
            reg_rd = len_q;
        end else if (ofs == `PCD_OFS_CTRL) begin
            reg_rd = {dma_busy, ctrl_q};
        end else if (ofs == `PCD_OFS_LMEM) begin
            reg_rd = lmem_addr_q;
        end else begin
            reg_rd = `PCD_RST_WORD;
        end
    end

    // any byte written to the control word starts an idle channel
    assign start = take && hit_reg && lnk.rq_write && (ofs == `PCD_OFS_CTRL)
                   && (lnk.rq_be != 4'h0) && !dma_busy;

    // control word after byte-lane merge; bit 31 is never stored
    assign ctrl_merged = merge_be({1'b0, ctrl_q}, lnk.rq_data, lnk.rq_be);

    // target ram writes
    always_ff @(posedge clk) begin
        if (take && hit_ram && lnk.rq_write) begin
            ram[ram_idx] <= merge_be(ram[ram_idx], lnk.rq_data, lnk.rq_be);
        end
    end

    // read completions one cycle after the request
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            cp_valid_q <= 1'b0;
            cp_data_q <= `PCD_RST_WORD;
        end else begin
            cp_valid_q <= take && !lnk.rq_write;
            if (take && !lnk.rq_write) begin
                if (hit_ram) begin
                    cp_data_q <= ram[ram_idx];
                end else if (hit_reg) begin
                    cp_data_q <= reg_rd;
                end else begin
                    cp_data_q <= `PCD_RST_WORD;
                end
            end
        end
    end

    assign lnk.cp_valid = cp_valid_q;
    assign lnk.cp_data = cp_data_q;

    // control register writes; setup words held while a dma runs
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            link_lo_q <= `PCD_RST_WORD;
            link_hi_q <= `PCD_RST_WORD;
            len_q <= `PCD_RST_WORD;
            ctrl_q <= 31'h0;
            lmem_addr_q <= `PCD_RST_WORD;
        end else if (take && hit_reg && lnk.rq_write && !dma_busy) begin
            if (ofs == `PCD_OFS_LINK_LO) begin
                link_lo_q <= merge_be(link_lo_q, lnk.rq_data, lnk.rq_be);
            end else if (ofs == `PCD_OFS_LINK_HI) begin
                link_hi_q <= merge_be(link_hi_q, lnk.rq_data, lnk.rq_be);
            end else if (ofs == `PCD_OFS_LENGTH) begin
                len_q <= merge_be(len_q, lnk.rq_data, lnk.rq_be);
            end else if (ofs == `PCD_OFS_CTRL) begin
                ctrl_q <= ctrl_merged[30:0];
            end else if (ofs == `PCD_OFS_LMEM) begin
                lmem_addr_q <= merge_be(lmem_addr_q, lnk.rq_data, lnk.rq_be);
            end
        end
    end

    // a beat ends on the write handshake or on returned read data
    assign beat_done = ((st_q == DMA_ISSUE) && lnk.dm_ready && lnk.dm_write)
                       || ((st_q == DMA_WAIT) && lnk.dr_valid);
    assign last_beat = (left_q <= `PCD_BEAT_BYTES);

    // dma engine
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            st_q <= DMA_IDLE;
            cur_link_q <= 64'h0;
            cur_lmem_q <= `PCD_RST_WORD;
            left_q <= `PCD_RST_WORD;
            dma_done <= 1'b0;
        end else begin
            dma_done <= 1'b0;
            case (st_q)
                DMA_IDLE: begin
                    if (start) begin
                        cur_link_q <= {link_hi_q, link_lo_q};
                        cur_lmem_q <= lmem_addr_q;
                        left_q <= len_q;
                        if (len_q == 32'h0) begin
                            dma_done <= 1'b1;
                        end else begin
                            st_q <= DMA_ISSUE;
                        end
                    end
                end
                DMA_ISSUE: begin
                    if (lnk.dm_ready && !lnk.dm_write) begin
                        st_q <= DMA_WAIT;
                    end
                end
                default: begin
                end
            endcase
            if (beat_done) begin
                cur_link_q <= cur_link_q + 64'h4;
                cur_lmem_q <= cur_lmem_q + `PCD_BEAT_BYTES;
                left_q <= last_beat ? 32'h0 : left_q - `PCD_BEAT_BYTES;
                if (last_beat) begin
                    st_q <= DMA_IDLE;
                    dma_done <= 1'b1;
                end else begin
                    st_q <= DMA_ISSUE;
                end
            end
        end
    end

    // local master memory: source for link writes, sink for link reads
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            for (int i = 0; i < LMEM_WORDS; i++) begin
                lmem[i] <= `PCD_RST_WORD;
            end
        end else if ((st_q == DMA_WAIT) && lnk.dr_valid) begin
            lmem[cur_lmem_q[LAW+1:2]] <= lnk.dr_data;
        end
    end

    assign dma_busy = (st_q != DMA_IDLE);
    assign lnk.dm_valid = (st_q == DMA_ISSUE);
    assign lnk.dm_write = ctrl_q[`PCD_CTRL_DIR_BIT];
    assign lnk.dm_addr = cur_link_q;
    assign lnk.dm_data = lmem[cur_lmem_q[LAW+1:2]];
endmodule
`default_nettype wire

// ---- pcd_link_assertions.sv ----
// concurrent checks on the link between host end and device end
// assumes one clock, active high async reset, full byte enables on register setup
`timescale 1ns/100ps
`default_nettype none
`include "pcd_defines.svh"
module pcd_link_assertions (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic rq_valid,
    input wire logic [2:0] rq_bar,
    input wire logic rq_write,
    input wire logic [63:0] rq_addr,
    input wire logic [31:0] rq_data,
    input wire logic [3:0] rq_be,
    input wire logic cp_valid,
    input wire logic [31:0] cp_data,
    input wire logic dm_valid,
    input wire logic dm_ready,
    input wire logic dm_write,
    input wire logic [63:0] dm_addr,
    input wire logic dr_valid
);
    logic [31:0] lo_q;
    logic [31:0] hi_q;
    logic [31:0] len_q;
    logic [31:0] beats_q;
    logic reg_wr;
    logic ctrl_rd;

    // full-word writes seen on the control bars, control word reads seen on bar 2 only
    assign reg_wr = rq_valid && rq_write && (rq_bar == 3'h2 || rq_bar == 3'h3) && rq_be == 4'hf;
    assign ctrl_rd = rq_valid && !rq_write && rq_bar == `PCD_BAR_CTRL
        && rq_addr[11:0] == `PCD_OFS_CTRL;

    // shadow of the setup words
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            lo_q <= 32'h0;
            hi_q <= 32'h0;
            len_q <= 32'h0;
        end else if (reg_wr) begin
            if (rq_addr[11:0] == `PCD_OFS_LINK_LO) lo_q <= rq_data;
            if (rq_addr[11:0] == `PCD_OFS_LINK_HI) hi_q <= rq_data;
            if (rq_addr[11:0] == `PCD_OFS_LENGTH) len_q <= rq_data;
        end
    end

    // beats taken since the last start
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            beats_q <= 32'h0;
        end else if (reg_wr && rq_addr[11:0] == `PCD_OFS_CTRL) begin
            beats_q <= 32'h0;
        end else if (dm_valid && dm_ready) begin
            beats_q <= beats_q + 32'h1;
        end
    end

    chk_read_gets_answer: assert property (@(posedge clk) disable iff (sys_rst)
        rq_valid && !rq_write && rq_bar <= 3'h5 |=> cp_valid)
        else $error("read request without completion");
    chk_no_stray_cpl: assert property (@(posedge clk) disable iff (sys_rst)
        cp_valid |-> $past(rq_valid) && !$past(rq_write))
        else $error("completion without a read");
    chk_start_first_beat: assert property (@(posedge clk) disable iff (sys_rst)
        reg_wr && rq_addr[11:0] == `PCD_OFS_CTRL && len_q != 32'h0 && !dm_valid
        |=> dm_valid && dm_addr == {hi_q, lo_q} && dm_write == $past(rq_data[0]))
        else $error("dma start wrong");
    chk_write_addr_step: assert property (@(posedge clk) disable iff (sys_rst)
        dm_valid && dm_ready && dm_write ##1 dm_valid |-> dm_addr == $past(dm_addr) + 64'h4)
        else $error("write beat address not stepped by four");
    chk_read_single: assert property (@(posedge clk) disable iff (sys_rst)
        dm_valid && !dm_write |=> !dm_valid)
        else $error("second read issued while one outstanding");
    chk_read_data_back: assert property (@(posedge clk) disable iff (sys_rst)
        dm_valid && dm_ready && !dm_write |=> dr_valid)
        else $error("read data not returned");
    chk_beat_limit: assert property (@(posedge clk) disable iff (sys_rst)
        dm_valid |-> beats_q < ((len_q + 32'h3) >> 2))
        else $error("more beats than the length allows");
    chk_busy_bit_read: assert property (@(posedge clk) disable iff (sys_rst)
        ctrl_rd && dm_valid |=> cp_valid && cp_data[`PCD_CTRL_BUSY_BIT])
        else $error("busy bit low during transfer");
endmodule
`default_nettype wire

// ---- pcie_endpoint_bar_decode_dma_regs_tb_top.sv ----
// testbench: host end and device end joined by the link, driven from the host user side
// assumes host memory word i holds i after reset and a zero local memory
`timescale 1ns/100ps
`default_nettype none
`include "pcd_defines.svh"
module pcie_endpoint_bar_decode_dma_regs_tb_top;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic cmd_valid = 1'b0;
    logic cmd_ready;
    logic cmd_write = 1'b0;
    logic [2:0] cmd_bar = 3'h0;
    logic [63:0] cmd_addr = 64'h0;
    logic [31:0] cmd_wdata = 32'h0;
    logic [3:0] cmd_be = 4'hf;
    logic rsp_valid;
    logic [31:0] rsp_data;
    logic dma_go = 1'b0;
    logic [63:0] dma_link_addr = 64'h0;
    logic [31:0] dma_local_addr = 32'h0;
    logic [31:0] dma_len = 32'h0;
    logic [30:0] dma_attr = 31'h0;
    logic dma_idle;
    logic dma_finished;
    logic dma_busy;
    logic dma_done;
    int errors = 0;
    int comparisons = 0;
    int mon_n = 0;
    int mon_done = 0;
    logic [63:0] mon_addr [0:7];
    logic [31:0] mon_data [0:7];
    logic mon_wr [0:7];

    pcd_link_if pcd_link_if_i ();
    pcd_dev_end pcd_dev_end_i (.clk(clk), .sys_rst(sys_rst), .lnk(pcd_link_if_i.dev),
        .dma_busy(dma_busy), .dma_done(dma_done));
    pcd_host_end pcd_host_end_i (.clk(clk), .sys_rst(sys_rst), .lnk(pcd_link_if_i.host),
        .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_write(cmd_write),
        .cmd_bar(cmd_bar), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .cmd_be(cmd_be),
        .rsp_valid(rsp_valid), .rsp_data(rsp_data), .dma_go(dma_go),
        .dma_link_addr(dma_link_addr), .dma_local_addr(dma_local_addr), .dma_len(dma_len),
        .dma_attr(dma_attr), .dma_idle(dma_idle), .dma_finished(dma_finished));
    pcd_link_assertions pcd_link_assertions_i (.clk(clk), .sys_rst(sys_rst),
        .rq_valid(pcd_link_if_i.rq_valid), .rq_bar(pcd_link_if_i.rq_bar),
        .rq_write(pcd_link_if_i.rq_write), .rq_addr(pcd_link_if_i.rq_addr),
        .rq_data(pcd_link_if_i.rq_data), .rq_be(pcd_link_if_i.rq_be),
        .cp_valid(pcd_link_if_i.cp_valid), .cp_data(pcd_link_if_i.cp_data),
        .dm_valid(pcd_link_if_i.dm_valid), .dm_ready(pcd_link_if_i.dm_ready),
        .dm_write(pcd_link_if_i.dm_write), .dm_addr(pcd_link_if_i.dm_addr),
        .dr_valid(pcd_link_if_i.dr_valid));

    // 50 MHz clock
    initial begin
        forever #10 clk = ~clk;
    end

    // record the first eight dma beats of each run taken on the link
    always @(posedge clk) begin
        if (dma_done === 1'b1) begin
            mon_done = mon_done + 1;
        end
        if (pcd_link_if_i.dm_valid === 1'b1 && pcd_link_if_i.dm_ready === 1'b1 && mon_n < 8) begin
            mon_addr[mon_n] = pcd_link_if_i.dm_addr;
            mon_data[mon_n] = pcd_link_if_i.dm_data;
            mon_wr[mon_n] = pcd_link_if_i.dm_write;
            mon_n = mon_n + 1;
        end
    end

    task automatic results();
        $display("errors=%0d comparisons=%0d", errors, comparisons);
        if (errors == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic timed_out();
        errors++;
        results();
    endtask

    task automatic check(input logic [63:0] got, input logic [63:0] exp);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // one user request; read data returned in rd
    task automatic host_req(input logic wr, input logic [2:0] bar, input logic [63:0] addr,
            input logic [31:0] data, output logic [31:0] rd);
        int n;
        @(posedge clk);
        cmd_valid <= 1'b1;
        cmd_write <= wr;
        cmd_bar <= bar;
        cmd_addr <= addr;
        cmd_wdata <= data;
        for (n = 0; n < 100; n++) begin
            @(posedge clk);
            if (cmd_ready === 1'b1) break;
        end
        cmd_valid <= 1'b0;
        if (n == 100) timed_out();
        rd = 32'h0;
        if (!wr) begin
            for (n = 0; n < 100; n++) begin
                @(posedge clk);
                if (rsp_valid === 1'b1) break;
            end
            if (n == 100) timed_out();
            rd = rsp_data;
        end
    endtask

    task automatic rd_chk(input logic [2:0] bar, input logic [63:0] addr, input logic [31:0] exp);
        logic [31:0] d;
        host_req(1'b0, bar, addr, 32'h0, d);
        check({32'h0, d}, {32'h0, exp});
    endtask

    task automatic run_dma(input logic [63:0] la, input logic [31:0] len, input logic [30:0] at);
        int n;
        mon_n = 0;
        mon_done = 0;
        @(posedge clk);
        dma_go <= 1'b1;
        dma_link_addr <= la;
        dma_len <= len;
        dma_attr <= at;
        for (n = 0; n < 100; n++) begin
            @(posedge clk);
            if (dma_idle === 1'b0) break;
        end
        dma_go <= 1'b0;
        if (n == 100) timed_out();
        for (n = 0; n < 1000; n++) begin
            @(posedge clk);
            if (dma_finished === 1'b1) break;
        end
        if (n == 1000) timed_out();
    endtask

    // target ram through all ram bars, aliased above bit 15
    task automatic test_ram();
        logic [31:0] d;
        host_req(1'b1, 3'h0, 64'h10, 32'ha5a5_0001, d);
        rd_chk(3'h4, 64'h1_0000_8010, 32'ha5a5_0001);
        host_req(1'b1, 3'h5, 64'h7ffc, 32'h5a5a_7ffc, d);
        rd_chk(3'h1, 64'hf_fffc, 32'h5a5a_7ffc);
    endtask

    // reset values, read back, unmapped offset
    task automatic test_regs();
        logic [31:0] d;
        rd_chk(3'h2, 64'h0c, `PCD_RST_WORD);
        host_req(1'b1, 3'h2, 64'h00, 32'h1111_2222, d);
        host_req(1'b1, 3'h3, 64'h04, 32'h3333_4444, d);
        host_req(1'b1, 3'h2, 64'h08, 32'h0000_0010, d);
        host_req(1'b1, 3'h2, 64'h14, 32'h0000_0020, d);
        rd_chk(3'h3, 64'h00, 32'h1111_2222);
        rd_chk(3'h2, 64'h04, 32'h3333_4444);
        rd_chk(3'h2, 64'h08, 32'h0000_0010);
        rd_chk(3'h3, 64'h14, 32'h0000_0020);
        rd_chk(3'h2, 64'h10, 32'h0);
        rd_chk(3'h0, 64'h8000_0010, 32'ha5a5_0001);
    endtask

    // link read of two words into local memory
    task automatic test_dma_read();
        dma_local_addr <= 32'h0000_0008;
        run_dma(64'h10, 32'h8, 31'h0);
        check(64'(mon_n), 64'h2);
        check(64'(mon_done), 64'h1);
        check(mon_addr[0], 64'h10);
        check(mon_addr[1], 64'h14);
        check({63'h0, mon_wr[0]}, 64'h0);
    endtask

    // link write of local words 1 and 2 to a high address
    task automatic test_dma_write();
        dma_local_addr <= 32'h0000_0004;
        run_dma(64'h1_0000_0040, 32'h8, 31'h1);
        check(64'(mon_n), 64'h2);
        check(64'(mon_done), 64'h1);
        check(mon_addr[0], 64'h1_0000_0040);
        check(mon_addr[1], 64'h1_0000_0044);
        check({63'h0, mon_wr[1]}, 64'h1);
        check({32'h0, mon_data[0]}, 64'h0);
        check({32'h0, mon_data[1]}, 64'h4);
        check({63'h0, dma_busy}, 64'h0);
        rd_chk(3'h2, 64'h0c, 32'h0000_0001);
        rd_chk(3'h2, 64'h04, 32'h0000_0001);
        rd_chk(3'h2, 64'h14, 32'h0000_0004);
    endtask

    // zero length: done pulse, no beats
    task automatic test_dma_empty();
        run_dma(64'h80, 32'h0, 31'h0);
        check(64'(mon_n), 64'h0);
        check(64'(mon_done), 64'h1);
        rd_chk(3'h2, 64'h08, 32'h0);
    endtask

    // main sequence
    initial begin
        repeat (16) @(posedge clk);
        sys_rst <= 1'b0;
        test_ram();
        test_regs();
        test_dma_read();
        test_dma_write();
        test_dma_empty();
        results();
    end
endmodule
`default_nettype wire
